// >>> inc/bgds_cfg.svh
/*
 * Timing counts, sequence lengths and encodings for the buck gate drive sequencer.
 * Assumes a 250 MHz control clock; times other than the enable filter, soft-start delay and sync loss are in ns and converted to cycles here.
 */
`ifndef BGDS_CFG_SVH
`define BGDS_CFG_SVH

`define BGDS_CLK_MHZ 250
`define BGDS_NS2CYC_DN(ns) (((ns) * `BGDS_CLK_MHZ) / 1000)
`define BGDS_NS2CYC_UP(ns) (((ns) * `BGDS_CLK_MHZ + 999) / 1000)

// Enable-low filter before switching stops (about 15 us).
`define BGDS_T_STOP_NS 15000
`define BGDS_STOP_CYC `BGDS_NS2CYC_DN(`BGDS_T_STOP_NS)
// Enable-high noise filter and soft-start delay, in cycles.
`define BGDS_EN_FILT_CYC 25
`define BGDS_SS_DLY_CYC 1000
// Bootstrap precharge burst: eight low-side pulses of 250 ns every 2 us.
`define BGDS_T_PRE_ON_NS 250
`define BGDS_PRE_ON_CYC `BGDS_NS2CYC_UP(`BGDS_T_PRE_ON_NS)
`define BGDS_T_PRE_PER_NS 2000
`define BGDS_PRE_PER_CYC `BGDS_NS2CYC_DN(`BGDS_T_PRE_PER_NS)
`define BGDS_PRE_COUNT 8
// Low-input operation: 19.5 us on-time, 200 ns off-time.
`define BGDS_T_LONG_ON_NS 19500
`define BGDS_LONG_ON_CYC `BGDS_NS2CYC_DN(`BGDS_T_LONG_ON_NS)
`define BGDS_T_LONG_OFF_NS 200
`define BGDS_LONG_OFF_CYC `BGDS_NS2CYC_UP(`BGDS_T_LONG_OFF_NS)
// Switch node decay window and forced low-side pulse.
`define BGDS_T_SW_WAIT_NS 70
`define BGDS_SW_WAIT_CYC `BGDS_NS2CYC_DN(`BGDS_T_SW_WAIT_NS)
`define BGDS_T_FORCE_NS 100
`define BGDS_FORCE_CYC `BGDS_NS2CYC_UP(`BGDS_T_FORCE_NS)
// Internal oscillator, 410 kHz.
`define BGDS_OSC_KHZ 410
`define BGDS_OSC_CYC ((`BGDS_CLK_MHZ * 1000) / `BGDS_OSC_KHZ)
`define BGDS_SYNC_LOSS_TICKS 4
// Burst after leaving pulse-skip: up to three pulses at a quarter of the clock.
`define BGDS_BURST_MAX 3
`define BGDS_BURST_DIV 4
// Error amplifier lower clamp selection.
`define BGDS_CLAMP_NONE 2'h0
`define BGDS_CLAMP_NORMAL 2'h1
`define BGDS_CLAMP_SKIP 2'h2
`define BGDS_CLAMP_BURST 2'h3

`endif

// >>> inc/bgds_cmp_if.sv
/*
 * Carries the synchronised comparator levels from the synchroniser to the sequencer.
 * Assumes both ends run on the control clock.
 */
`timescale 1ns/1ps
interface bgds_cmp_if;
    logic sw_low;
    logic lsg_low;
    logic zero_cur;
    modport src (output sw_low, output lsg_low, output zero_cur);
    modport dst (input sw_low, input lsg_low, input zero_cur);
endinterface : bgds_cmp_if

// >>> inc/bgds_pkg.sv
/*
 * Types shared by the buck gate drive sequencer.
 * Assumes bgds_cfg.svh is used for every number.
 */
package bgds_pkg;

    typedef enum logic [5:0] {
        BGDS_OFF      = 6'h01,
        BGDS_EN_FILT  = 6'h02,
        BGDS_SS_DELAY = 6'h04,
        BGDS_PRECHG   = 6'h08,
        BGDS_RUN      = 6'h10,
        BGDS_STOPPING = 6'h20
    } bgds_state_t;

endpackage : bgds_pkg

// >>> rtl/bgds_cmp_sync.sv
/*
 * Two-flop synchroniser for the analog comparator outputs.
 * Assumes the comparators are asynchronous to the control clock.
 */
`timescale 1ns/1ps
module bgds_cmp_sync (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [2:0] raw_i,
    bgds_cmp_if.src cmp
);
    logic [2:0] meta_q;
    logic [2:0] sync_q;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
        end else begin
            meta_q <= raw_i;
            sync_q <= meta_q;
        end
    end

    assign cmp.sw_low = sync_q[0];
    assign cmp.lsg_low = sync_q[1];
    assign cmp.zero_cur = sync_q[2];
endmodule : bgds_cmp_sync

// >>> rtl/bgds_top.sv
/*
 * Enable/shutdown sequencing, bootstrap precharge and non-overlap gate drive for a buck controller.
 * Assumes analog comparators outside, a current loop that reports peak trip, and logic-level inputs
 * that are synchronous to CLK_I except the three comparators.
 */
`timescale 1ns/1ps
`include "bgds_cfg.svh"
module bgds_top
    import bgds_pkg::*;
#(
    parameter logic [12:0] LONG_ON_CYC = 13'(`BGDS_LONG_ON_CYC)
) (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic EN_I,
    input wire logic VIN_ABOVE_DISCH_I,
    input wire logic LOW_INPUT_THRESHOLD_I,
    input wire logic VOUT_LOW_I,
    input wire logic DUTY_MAX_I,
    input wire logic PEAK_TRIP_I,
    input wire logic SKIP_REQ_I,
    input wire logic SYNC_INPUT_I,
    input wire logic SW_NODE_LOW_I,
    input wire logic LSG_LOW_I,
    input wire logic ZERO_CUR_I,
    output logic HIGH_SIDE_GATE_O,
    output logic LOW_SIDE_GATE_O,
    output logic DISCHARGE_O,
    output logic SOFT_START_RUN_O,
    output logic LOW_IQ_O,
    output logic [1:0] CLAMP_SEL_O
);
    bgds_cmp_if cmp ();

    bgds_cmp_sync u_sync (
        .clk_i(CLK_I),
        .reset_n_i(RESET_N_I),
        .raw_i({ZERO_CUR_I, LSG_LOW_I, SW_NODE_LOW_I}),
        .cmp(cmp)
    );

    bgds_state_t state_q;
    bgds_state_t state_d;
    logic [12:0] seq_cnt_q;
    logic [2:0] pre_cnt_q;
    logic [9:0] osc_cnt_q;
    logic [12:0] hs_cnt_q;
    logic hs_on_q;
    logic [6:0] dt_cnt_q;
    logic ls_wait_q;
    logic ls_on_q;
    logic force_q;
    logic sync_prev_q;
    logic [4:0] sync_cnt_q;
    logic refresh_q;
    logic [2:0] sync_idle_q;
    logic skip_prev_q;
    logic [1:0] burst_q;
    logic [1:0] burst_div_q;
    logic hs_gate_q;
    logic ls_gate_q;
    logic disch_q;
    logic ss_run_q;
    logic low_iq_q;
    logic [1:0] clamp_q;

    wire run = (state_q == BGDS_RUN) || (state_q == BGDS_STOPPING);
    wire seq_done_filt = seq_cnt_q == 13'(`BGDS_EN_FILT_CYC - 1);
    wire seq_done_ss = seq_cnt_q == 13'(`BGDS_SS_DLY_CYC - 1);
    wire seq_done_pre = seq_cnt_q == 13'(`BGDS_PRE_PER_CYC - 1);
    wire seq_done_stop = seq_cnt_q == 13'(`BGDS_STOP_CYC - 1);
    wire pre_last = pre_cnt_q == 3'(`BGDS_PRE_COUNT - 1);
    wire pre_pulse = (state_q == BGDS_PRECHG) && (seq_cnt_q < 13'(`BGDS_PRE_ON_CYC));
    wire tick = osc_cnt_q == 10'(`BGDS_OSC_CYC - 1);
    wire sync_rise = SYNC_INPUT_I && !sync_prev_q;
    wire sync_mode = sync_idle_q != 3'h0;
    wire diode_mode = !sync_mode;
    wire skipping = diode_mode && SKIP_REQ_I;
    wire long_mode = LOW_INPUT_THRESHOLD_I && VOUT_LOW_I;
    wire in_burst = burst_q != 2'h0;
    wire burst_slot = !in_burst || (burst_div_q == 2'h0);
    wire zero_ok = diode_mode && !LOW_INPUT_THRESHOLD_I && !skipping;
    wire off_done = hs_cnt_q >= (long_mode ? 13'(`BGDS_LONG_OFF_CYC) : 13'h0001);
    // In low-input recovery the 19.7 us period runs from the off timer, not from the oscillator.
    wire start_evt = long_mode ? off_done : (sync_mode ? sync_rise : tick);
    wire hs_start = run && !hs_on_q && start_evt && off_done && !skipping && burst_slot
                    && !(zero_ok && PEAK_TRIP_I);
    wire hold_off_pulse = DUTY_MAX_I && LOW_INPUT_THRESHOLD_I;
    wire hs_end_long = long_mode && (hs_cnt_q >= LONG_ON_CYC - 13'h0001);
    wire hs_end_norm = !long_mode && (PEAK_TRIP_I || (tick && !hold_off_pulse));
    wire hs_end = hs_on_q && (hs_end_long || hs_end_norm || !run);
    wire sw_wait_over = dt_cnt_q == 7'(`BGDS_SW_WAIT_CYC - 1);
    wire ls_stop = hs_start || (diode_mode && cmp.zero_cur) || !run;
    wire ls_gate_d = (ls_on_q && cmp.sw_low && !hs_on_q) || force_q || refresh_q || pre_pulse;
    wire hs_gate_d = hs_on_q && !hs_end && cmp.lsg_low && !ls_gate_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            BGDS_OFF: if (EN_I) state_d = BGDS_EN_FILT;
            BGDS_EN_FILT: begin
                if (!EN_I) state_d = BGDS_OFF;
                else if (seq_done_filt) state_d = BGDS_SS_DELAY;
            end
            BGDS_SS_DELAY: begin
                if (!EN_I) state_d = BGDS_OFF;
                else if (seq_done_ss) state_d = BGDS_PRECHG;
            end
            BGDS_PRECHG: begin
                if (!EN_I) state_d = BGDS_OFF;
                else if (seq_done_pre && pre_last) state_d = BGDS_RUN;
            end
            BGDS_RUN: if (!EN_I) state_d = BGDS_STOPPING;
            BGDS_STOPPING: begin
                // A re-enable during the stop filter still ends in shutdown, so the next start is full.
                if (seq_done_stop) state_d = BGDS_OFF;
            end
            default: state_d = BGDS_OFF;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_q <= BGDS_OFF;
            seq_cnt_q <= 13'h0000;
            pre_cnt_q <= 3'h0;
        end else begin
            state_q <= state_d;
            seq_cnt_q <= (state_d != state_q || (state_q == BGDS_PRECHG && seq_done_pre))
                         ? 13'h0000 : seq_cnt_q + 13'h0001;
            if (state_q != BGDS_PRECHG) pre_cnt_q <= 3'h0;
            else if (seq_done_pre) pre_cnt_q <= pre_cnt_q + 3'h1;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            osc_cnt_q <= 10'h000;
            sync_prev_q <= 1'b0;
            sync_idle_q <= 3'h0;
            sync_cnt_q <= 5'h00;
            refresh_q <= 1'b0;
        end else begin
            // The internal clock keeps its rate whether or not off pulses are skipped.
            osc_cnt_q <= (tick || !run) ? 10'h000 : osc_cnt_q + 10'h001;
            sync_prev_q <= SYNC_INPUT_I;
            if (sync_rise) sync_idle_q <= 3'(`BGDS_SYNC_LOSS_TICKS);
            else if (tick && sync_mode) sync_idle_q <= sync_idle_q - 3'h1;
            if (sync_rise) sync_cnt_q <= 5'h00;
            else if (SYNC_INPUT_I && sync_cnt_q != 5'h1f) sync_cnt_q <= sync_cnt_q + 5'h01;
            // Ending the refresh at the sync fall bounds it to the sync width less 70 ns.
            if (!SYNC_INPUT_I || !run) refresh_q <= 1'b0;
            else if (sync_cnt_q == 5'(`BGDS_SW_WAIT_CYC - 1) && !cmp.sw_low) refresh_q <= 1'b1;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            hs_on_q <= 1'b0;
            hs_cnt_q <= 13'h0000;
        end else if (hs_start) begin
            hs_on_q <= 1'b1;
            hs_cnt_q <= 13'h0000;
        end else if (hs_end) begin
            hs_on_q <= 1'b0;
            hs_cnt_q <= 13'h0000;
        end else if (hs_cnt_q != 13'h1fff) begin
            hs_cnt_q <= hs_cnt_q + 13'h0001;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ls_wait_q <= 1'b0;
            ls_on_q <= 1'b0;
            force_q <= 1'b0;
            dt_cnt_q <= 7'h00;
        end else if (hs_end) begin
            ls_wait_q <= 1'b1;
            ls_on_q <= 1'b0;
            dt_cnt_q <= 7'h00;
        end else if (ls_stop) begin
            ls_wait_q <= 1'b0;
            ls_on_q <= 1'b0;
            force_q <= 1'b0;
        end else if (ls_wait_q) begin
            dt_cnt_q <= dt_cnt_q + 7'h01;
            if (cmp.sw_low) begin
                ls_wait_q <= 1'b0;
                ls_on_q <= 1'b1;
            end else if (sw_wait_over) begin
                ls_wait_q <= 1'b0;
                ls_on_q <= 1'b1;
                force_q <= 1'b1;
                dt_cnt_q <= 7'h00;
            end
        end else if (force_q) begin
            dt_cnt_q <= dt_cnt_q + 7'h01;
            if (dt_cnt_q == 7'(`BGDS_FORCE_CYC - 1)) force_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            skip_prev_q <= 1'b0;
            burst_q <= 2'h0;
            burst_div_q <= 2'h0;
        end else begin
            skip_prev_q <= skipping;
            if (skip_prev_q && !skipping) burst_q <= 2'(`BGDS_BURST_MAX);
            else if (hs_start && in_burst) burst_q <= burst_q - 2'h1;
            if (tick) burst_div_q <= burst_div_q + 2'h1;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            hs_gate_q <= 1'b0;
            ls_gate_q <= 1'b0;
            disch_q <= 1'b0;
            ss_run_q <= 1'b0;
            low_iq_q <= 1'b0;
            clamp_q <= `BGDS_CLAMP_NONE;
        end else begin
            hs_gate_q <= hs_gate_d && !ls_gate_d;
            ls_gate_q <= ls_gate_d && !hs_gate_q;
            disch_q <= (state_q == BGDS_OFF) && VIN_ABOVE_DISCH_I;
            ss_run_q <= run;
            low_iq_q <= run && skipping;
            if (!run) clamp_q <= `BGDS_CLAMP_NONE;
            else if (skipping) clamp_q <= `BGDS_CLAMP_SKIP;
            else if (in_burst) clamp_q <= `BGDS_CLAMP_BURST;
            else clamp_q <= `BGDS_CLAMP_NORMAL;
        end
    end

    assign HIGH_SIDE_GATE_O = hs_gate_q;
    assign LOW_SIDE_GATE_O = ls_gate_q;
    assign DISCHARGE_O = disch_q;
    assign SOFT_START_RUN_O = ss_run_q;
    assign LOW_IQ_O = low_iq_q;
    assign CLAMP_SEL_O = clamp_q;
endmodule : bgds_top

// >>> sim/bgds_bridge.sv
/* Behavioural half bridge: switch node and low gate comparators, zero current sense.
   Assumes the gate outputs of the sequencer drive it on the control clock. */
`timescale 1ns/1ps
module bgds_bridge (
    input wire logic clk_i,
    input wire logic hs_i,
    input wire logic ls_i,
    input wire logic slow_i,
    output logic sw_low_o,
    output logic lsg_low_o,
    output logic zero_cur_o
);
    logic [5:0] hs_off_q = 6'h3f;
    logic [5:0] ls_on_q = 6'h00;
    logic ls_q = 1'b0;
    always_ff @(posedge clk_i) begin
        hs_off_q <= hs_i ? 6'h00 : (hs_off_q == 6'h3f ? hs_off_q : hs_off_q + 6'h01);
        ls_on_q <= ls_i ? (ls_on_q == 6'h3f ? ls_on_q : ls_on_q + 6'h01) : 6'h00;
        ls_q <= ls_i;
    end
    // A slow node outlasts the decay window, so the forced low-side pulse is exercised.
    assign sw_low_o = ls_i || (!hs_i && hs_off_q >= (slow_i ? 6'h28 : 6'h03));
    assign lsg_low_o = !ls_q;
    assign zero_cur_o = ls_i && ls_on_q >= 6'h1e;
endmodule : bgds_bridge

// >>> sim/bgds_top_sva.sv
/* Concurrent checks on the gate drive sequencer top ports.
   Assumes it is bound to bgds_top and sees only its ports. */
`timescale 1ns/1ps
`include "bgds_cfg.svh"
module bgds_top_sva #(
    parameter logic [12:0] LONG_ON_CYC = 13'h0064
) (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic EN_I,
    input wire logic VIN_ABOVE_DISCH_I,
    input wire logic HIGH_SIDE_GATE_O,
    input wire logic LOW_SIDE_GATE_O,
    input wire logic DISCHARGE_O,
    input wire logic SOFT_START_RUN_O,
    input wire logic LOW_IQ_O,
    input wire logic [1:0] CLAMP_SEL_O
);
    logic [7:0] lg_cnt_q;
    // Counts how long the low gate has been high, so pulse widths can be checked beyond repetition limits.
    always_ff @(posedge CLK_I or negedge RESET_N_I)
        if (!RESET_N_I) lg_cnt_q <= 8'h00;
        else lg_cnt_q <= LOW_SIDE_GATE_O ? lg_cnt_q + 8'h01 : 8'h00;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    property p_no_overlap; !(HIGH_SIDE_GATE_O && LOW_SIDE_GATE_O); endproperty
    property p_hs_after_ls; $rose(HIGH_SIDE_GATE_O) |-> !$past(LOW_SIDE_GATE_O); endproperty
    property p_ss_clamp; $rose(SOFT_START_RUN_O) |-> CLAMP_SEL_O == `BGDS_CLAMP_NORMAL; endproperty
    property p_clamp_start; !SOFT_START_RUN_O |-> CLAMP_SEL_O == `BGDS_CLAMP_NONE; endproperty
    property p_low_iq; LOW_IQ_O |-> CLAMP_SEL_O == `BGDS_CLAMP_SKIP; endproperty
    property p_shut; (!EN_I && !SOFT_START_RUN_O)[*3] |=> !HIGH_SIDE_GATE_O && !LOW_SIDE_GATE_O; endproperty
    property p_ss_stands; $fell(EN_I) && SOFT_START_RUN_O |=> SOFT_START_RUN_O[*8]; endproperty
    property p_prechg;
        $fell(LOW_SIDE_GATE_O) && !SOFT_START_RUN_O && EN_I |-> lg_cnt_q == 8'(`BGDS_PRE_ON_CYC);
    endproperty
    property p_dis_on; (!EN_I && !SOFT_START_RUN_O && VIN_ABOVE_DISCH_I)[*3] |=> DISCHARGE_O; endproperty
    property p_dis_off; DISCHARGE_O |-> $past(VIN_ABOVE_DISCH_I) && !SOFT_START_RUN_O; endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("both gates high");
    a_hs_after_ls: assert property (p_hs_after_ls) else $error("high gate rose after low gate");
    a_ss_clamp: assert property (p_ss_clamp) else $error("clamp not normal at ramp start");
    a_clamp_start: assert property (p_clamp_start) else $error("clamp active in startup");
    a_low_iq: assert property (p_low_iq) else $error("low quiescent without skip clamp");
    a_shut: assert property (p_shut) else $error("gate active in shutdown");
    a_ss_stands: assert property (p_ss_stands) else $error("switching stopped too early");
    a_prechg: assert property (p_prechg) else $error("precharge pulse width wrong");
    a_dis_on: assert property (p_dis_on) else $error("discharge missing in shutdown");
    a_dis_off: assert property (p_dis_off) else $error("discharge without cause");
    c_ramp: cover property ($rose(SOFT_START_RUN_O));
    c_low_iq: cover property (LOW_IQ_O);
    c_high: cover property ($rose(HIGH_SIDE_GATE_O));
endmodule : bgds_top_sva

// >>> sim/test_buck_gate_drive_sequencer.sv
/* Self-checking bench for the gate drive sequencer: enable abort, precharge, ramp start, random run, stop.
   Assumes the half bridge model and the port checker sit beside the design. */
`timescale 1ns/1ps
`include "bgds_cfg.svh"
module test_buck_gate_drive_sequencer;
    logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, vin_dis = 1'b0, low_input_threshold = 1'b0, vout_low = 1'b0;
    logic duty_max = 1'b0, peak = 1'b0, skip = 1'b0, sync = 1'b0, slow = 1'b0;
    logic hs, ls, dis, ss, low_iq, sw_low, lsg_low, zero_cur, lg_p = 1'b0, ss_p = 1'b0, hs_p = 1'b0;
    logic [1:0] clamp;
    logic [31:0] exp_q[$];
    logic [31:0] cyc = 0, en_at = 0, off_at = 0, width = 0, r;
    int err_total = 0, n_tests = 0;
    int hs_n = 0, iq_n = 0;
    bgds_top #(.LONG_ON_CYC(13'h0064)) dut (.CLK_I(clk), .RESET_N_I(rst_n), .EN_I(en),
        .VIN_ABOVE_DISCH_I(vin_dis), .LOW_INPUT_THRESHOLD_I(low_input_threshold), .VOUT_LOW_I(vout_low), .DUTY_MAX_I(duty_max),
        .PEAK_TRIP_I(peak), .SKIP_REQ_I(skip), .SYNC_INPUT_I(sync), .SW_NODE_LOW_I(sw_low),
        .LSG_LOW_I(lsg_low), .ZERO_CUR_I(zero_cur), .HIGH_SIDE_GATE_O(hs), .LOW_SIDE_GATE_O(ls),
        .DISCHARGE_O(dis), .SOFT_START_RUN_O(ss), .LOW_IQ_O(low_iq), .CLAMP_SEL_O(clamp));
    bgds_bridge bridge (.clk_i(clk), .hs_i(hs), .ls_i(ls), .slow_i(slow), .sw_low_o(sw_low),
        .lsg_low_o(lsg_low), .zero_cur_o(zero_cur));
    initial begin
        forever #2 clk = ~clk;
    end
    task check(input logic [31:0] seen, input logic [31:0] expv);
        n_tests++;
        if (seen !== expv) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask : check
    function logic [31:0] pop();
        if (exp_q.size() == 0) return 32'hffff_ffff;
        return exp_q.pop_front();
    endfunction : pop
    task print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    // Random mode flips each analog-side mode level about once in 256 cycles, so a condition lasts less than one 609-cycle switching period.
    task step(input int n, input logic rnd);
        repeat (n) begin
            @(posedge clk);
            r = $urandom;
            vin_dis <= r[31];
            if (rnd) begin
                peak <= r[5:0] == 6'h00;
                if (r[13:6] == 8'h00) low_input_threshold <= !low_input_threshold;
                if (r[13:6] == 8'h01) skip <= !skip;
                if (r[21:14] == 8'h00) vout_low <= !vout_low;
                if (r[21:14] == 8'h01) slow <= !slow;
                if (r[23:16] == 8'h02) duty_max <= !duty_max;
                // Sync pauses for long stretches, so diode emulation and its low quiescent state are reached.
                if (r[29:24] == 6'h00 && cyc[13]) sync <= !sync;
            end
        end
    endtask : step
    // Results are taken at the falling edge, where the registered outputs have settled.
    always @(negedge clk) begin
        if (lg_p && !ls && !ss && en) check(width, pop());
        if (!ss_p && ss) check(cyc - en_at, pop());
        if (!ss_p && ss) check(32'(clamp), 32'(`BGDS_CLAMP_NORMAL));
        if (hs && !hs_p) hs_n++;
        if (low_iq) iq_n++;
        hs_p = hs;
        if (ss_p && !ss) check(32'(cyc - off_at >= `BGDS_STOP_CYC && cyc - off_at <= `BGDS_STOP_CYC + 3), pop());
        width = ls ? width + 1 : 0;
        lg_p = ls;
        ss_p = ss;
        cyc = cyc + 1;
    end
    initial begin
        void'($urandom(32'h7fd48e1c));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        step(20, 1'b0);
        en <= 1'b1;
        step(10, 1'b0);
        en <= 1'b0;
        step(50, 1'b0);
        repeat (`BGDS_PRE_COUNT) exp_q.push_back(`BGDS_PRE_ON_CYC);
        // One cycle for the enable to be sampled and one for the registered ramp output.
        exp_q.push_back(`BGDS_EN_FILT_CYC + `BGDS_SS_DLY_CYC + `BGDS_PRE_COUNT * `BGDS_PRE_PER_CYC + 2);
        en <= 1'b1;
        en_at = cyc;
        for (int k = 0; k < 6000 && ss !== 1'b1; k++) step(1, 1'b0);
        step(20000, 1'b1);
        exp_q.push_back(32'h0000_0001);
        en <= 1'b0;
        off_at = cyc;
        for (int k = 0; k < 5000 && ss !== 1'b0; k++) step(1, 1'b1);
        step(50, 1'b0);
        check(32'(hs_n != 0), 32'h0000_0001);
        check(32'(iq_n != 0), 32'h0000_0001);
        check(32'(exp_q.size()), 32'h0000_0000);
        print_verdict();
    end
    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        print_verdict();
    end
endmodule : test_buck_gate_drive_sequencer

bind bgds_top bgds_top_sva #(.LONG_ON_CYC(LONG_ON_CYC)) checker_i (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
    .EN_I(EN_I), .VIN_ABOVE_DISCH_I(VIN_ABOVE_DISCH_I), .HIGH_SIDE_GATE_O(HIGH_SIDE_GATE_O),
    .LOW_SIDE_GATE_O(LOW_SIDE_GATE_O), .DISCHARGE_O(DISCHARGE_O), .SOFT_START_RUN_O(SOFT_START_RUN_O),
    .LOW_IQ_O(LOW_IQ_O), .CLAMP_SEL_O(CLAMP_SEL_O));
